// >>> rtl/ifp_addr_gen.sv
`timescale 1ns/1ns
module ifp_addr_gen
    import ifp_pkg::*;
(
    input wire logic [3:0] base_field_i,
    input wire logic [31:0] base_data_i,
    input wire logic [11:0] disp_i,
    input wire logic [11:0] offset_i,
    input wire logic offset_en_i,
    output logic [ADDR_W-1:0] addr_o
);

    logic [ADDR_W-1:0] base;
    logic [ADDR_W-1:0] ofs;

    // A zero field means no base, never the contents of register zero.
    assign base = (base_field_i == 4'h0) ? '0 : base_data_i[ADDR_W-1:0];
    assign ofs = offset_en_i ? {12'h000, offset_i} : '0;
    assign addr_o = ADDR_W'(base + {12'h000, disp_i} + ofs);

endmodule : ifp_addr_gen

// >>> rtl/ifp_decode.sv
`timescale 1ns/1ns
module ifp_decode
    import ifp_pkg::*;
(
    input wire logic clock_i,
    input wire logic arst_n_i,
    input wire logic instr_valid_i,
    input wire logic [0:INSTR_W-1] instr_i,
    input wire logic [31:0] gpr_data_a_i,
    input wire logic [31:0] gpr_data_b_i,
    input wire logic [0:31] reloc_word_i,
    input wire logic reloc_req_i,
    input wire logic psw_load_i,
    input wire logic [0:PSW_W-1] psw_new_i,
    input wire logic sys_mask_load_i,
    input wire logic [0:NMASK-1] sys_mask_i,
    input wire logic prog_mask_load_i,
    input wire logic [5:0] prog_mask_i,
    input wire logic exec_update_i,
    input wire logic [1:0] ilc_i,
    input wire logic [1:0] cc_i,
    input wire logic [21:0] next_ia_i,
    input wire logic branch_link_i,
    input wire logic [0:NMASK-1] irq_pending_i,
    output logic [3:0] gpr_addr_a_o,
    output logic [3:0] gpr_addr_b_o,
    output logic dec_valid_o,
    output logic [1:0] fmt_o,
    output logic [7:0] opcode_o,
    output logic [3:0] reg1_o,
    output logic [3:0] reg3_o,
    output logic reg3_valid_o,
    output logic [7:0] imm_byte_o,
    output logic [1:0] imm_use_o,
    output logic [ADDR_W-1:0] addr1_o,
    output logic [ADDR_W-1:0] addr2_o,
    output logic shift_o,
    output logic [5:0] shift_count_o,
    output logic io_o,
    output logic [3:0] io_chan_o,
    output logic [7:0] io_dev_o,
    output logic [7:0] len1_o,
    output logic [7:0] len2_o,
    output logic len2_valid_o,
    output logic secop_valid_o,
    output logic [0:PSW_W-1] psw_o,
    output logic [31:0] link_word_o,
    output logic link_valid_o,
    output logic [0:NMASK-1] irq_allowed_o,
    output logic [2:0] mode_sel_o,
    output logic mode_undef_o
);

    typedef struct packed {
        logic s1_vld;
        logic [0:INSTR_W-1] s1_ins;
        logic [3:0] rd_a;
        logic [3:0] rd_b;
        logic vld;
        logic [1:0] fmt;
        logic [7:0] op;
        logic [3:0] reg1;
        logic [3:0] reg3;
        logic reg3_vld;
        logic [7:0] imm;
        logic [1:0] imm_use;
        logic [ADDR_W-1:0] addr1;
        logic [ADDR_W-1:0] addr2;
        logic shift;
        logic [5:0] shcnt;
        logic io;
        logic [11:0] io_sel;
        logic [7:0] len1;
        logic [7:0] len2;
        logic len2_vld;
        logic secop_vld;
        logic [0:PSW_W-1] current_program_status;
        logic [31:0] link;
        logic link_vld;
        logic [0:NMASK-1] irq_ok;
        logic mode_undef;
    } ifp_state_t;

    ifp_state_t cur_ff;
    ifp_state_t nxt_cur;

    logic [0:INSTR_W-1] ins;
    logic [7:0] op;
    logic is_ss;
    logic is_rs;
    logic is_si;
    logic is_shift;
    logic is_io;
    logic [11:0] reloc_ofs;
    logic [ADDR_W-1:0] agen_a;
    logic [ADDR_W-1:0] agen_b;
    logic [3:0] base_b;
    logic [11:0] disp_b;
    logic [7:0] ld_len1;
    logic [7:0] ld_len2;
    logic ld_len2_vld;
    logic ld_secop;
    logic [0:NMASK-1] irq_gate;
    logic [2:0] msel_new;

    assign ins = cur_ff.s1_ins;
    assign op = ins[OP_HI:OP_LO];
    assign is_ss = (op[7:6] == TOP_SS);
    assign is_rs = (op[7:4] == NIB_RS);
    assign is_si = (op[7:6] == TOP_RSSI) && !is_rs;
    assign is_shift = is_rs && (op >= SHIFT_LO) && (op <= SHIFT_HI);
    assign is_io = is_si && (op >= IO_LO) && (op <= IO_HI);
    assign reloc_ofs = reloc_word_i[RELOC_HI:RELOC_LO];

    // Port A serves the first base of storage-immediate and storage-storage and the only base
    // of register-storage, so one adder covers all offsets that may need relocation.
    ifp_addr_gen u_agen_a (
        .base_field_i(ins[B1_HI:B1_LO]),
        .base_data_i(gpr_data_a_i),
        .disp_i(ins[D1_HI:D1_LO]),
        .offset_i(reloc_ofs),
        .offset_en_i(reloc_req_i && !is_rs),
        .addr_o(agen_a)
    );

    assign base_b = ins[B2_HI:B2_LO];
    assign disp_b = ins[D2_HI:D2_LO];

    ifp_addr_gen u_agen_b (
        .base_field_i(base_b),
        .base_data_i(gpr_data_b_i),
        .disp_i(disp_b),
        .offset_i(reloc_ofs),
        .offset_en_i(1'b0),
        .addr_o(agen_b)
    );

    ifp_len_decode u_len (
        .op_i(op),
        .len_byte_i(ins[R1_HI:R3_LO]),
        .len1_o(ld_len1),
        .len2_o(ld_len2),
        .len2_vld_o(ld_len2_vld),
        .secop_vld_o(ld_secop)
    );

    genvar g;
    generate
        for (g = 0; g < NMASK; g++)
        begin : gen_mask
            assign irq_gate[g] = irq_pending_i[g] & cur_ff.current_program_status[SM_HI + g];
        end
    endgenerate

    always_comb
    begin
        nxt_cur = cur_ff;
        msel_new = 3'h0;
        nxt_cur.s1_vld = instr_valid_i;
        if (instr_valid_i)
        begin
            nxt_cur.s1_ins = instr_i;
            nxt_cur.rd_a = instr_i[B1_HI:B1_LO];
            nxt_cur.rd_b = instr_i[B2_HI:B2_LO];
        end
        nxt_cur.vld = cur_ff.s1_vld;
        if (cur_ff.s1_vld)
        begin
            nxt_cur.op = op;
            nxt_cur.fmt = is_ss ? FMT_SS : (is_rs ? FMT_RS : (is_si ? FMT_SI : FMT_NONE));
            nxt_cur.reg1 = is_rs ? ins[R1_HI:R1_LO] : 4'h0;
            nxt_cur.reg3_vld = is_rs && !is_shift;
            nxt_cur.reg3 = (is_rs && !is_shift) ? ins[R3_HI:R3_LO] : 4'h0;
            nxt_cur.imm = is_si ? ins[R1_HI:R3_LO] : 8'h00;
            if (!is_si || op == OP_IMM_NONE)
                nxt_cur.imm_use = IMM_IGNORED;
            else if (is_io)
                nxt_cur.imm_use = IMM_SECOP;
            else if (op == OP_MASK_TEST)
                nxt_cur.imm_use = IMM_MASK;
            else
                nxt_cur.imm_use = IMM_OPERAND;
            // Register-storage keeps its one operand address on the second output.
            nxt_cur.addr1 = is_rs ? '0 : agen_a;
            nxt_cur.addr2 = is_rs ? agen_a : (is_ss ? agen_b : '0);
            nxt_cur.shift = is_shift;
            nxt_cur.shcnt = is_shift ? agen_a[5:0] : 6'h00;
            nxt_cur.io = is_io;
            nxt_cur.io_sel = is_io ? ins[D1_HI:D1_LO] : 12'h000;
            nxt_cur.len1 = is_ss ? ld_len1 : 8'h00;
            nxt_cur.len2 = is_ss ? ld_len2 : 8'h00;
            nxt_cur.len2_vld = is_ss && ld_len2_vld;
            nxt_cur.secop_vld = is_ss && ld_secop;
        end
        // A full replacement outranks every partial update in the same cycle.
        if (psw_load_i)
        begin
            nxt_cur.current_program_status = psw_new_i;
        end
        else
        begin
            if (sys_mask_load_i)
                nxt_cur.current_program_status[SM_HI:SM_LO] = sys_mask_i;
            if (prog_mask_load_i)
                nxt_cur.current_program_status[PM_HI:PM_LO] = prog_mask_i;
            if (exec_update_i)
            begin
                nxt_cur.current_program_status[ILC_HI:ILC_LO] = ilc_i;
                nxt_cur.current_program_status[CC_HI:CC_LO] = cc_i;
                nxt_cur.current_program_status[IA_HI:IA_LO] = next_ia_i;
            end
        end
        nxt_cur.link_vld = branch_link_i;
        if (branch_link_i)
            nxt_cur.link = cur_ff.current_program_status[LOW_HI:LOW_LO];
        nxt_cur.irq_ok = irq_gate;
        msel_new = nxt_cur.current_program_status[MSEL_HI:MSEL_LO];
        // Undefined codes are flagged only; behaviour under them is left to software.
        nxt_cur.mode_undef = (msel_new == MSEL_UNDEF_A) || (msel_new == MSEL_UNDEF_B) ||
                             (msel_new == MSEL_UNDEF_C);
    end

    always_ff @(posedge clock_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            cur_ff <= '0;
            cur_ff.current_program_status <= PSW_RST;
        end
        else
        begin
            cur_ff <= nxt_cur;
        end
    end

    assign gpr_addr_a_o = cur_ff.rd_a;
    assign gpr_addr_b_o = cur_ff.rd_b;
    assign dec_valid_o = cur_ff.vld;
    assign fmt_o = cur_ff.fmt;
    assign opcode_o = cur_ff.op;
    assign reg1_o = cur_ff.reg1;
    assign reg3_o = cur_ff.reg3;
    assign reg3_valid_o = cur_ff.reg3_vld;
    assign imm_byte_o = cur_ff.imm;
    assign imm_use_o = cur_ff.imm_use;
    assign addr1_o = cur_ff.addr1;
    assign addr2_o = cur_ff.addr2;
    assign shift_o = cur_ff.shift;
    assign shift_count_o = cur_ff.shcnt;
    assign io_o = cur_ff.io;
    assign io_chan_o = cur_ff.io_sel[11:8];
    assign io_dev_o = cur_ff.io_sel[7:0];
    assign len1_o = cur_ff.len1;
    assign len2_o = cur_ff.len2;
    assign len2_valid_o = cur_ff.len2_vld;
    assign secop_valid_o = cur_ff.secop_vld;
    assign psw_o = cur_ff.current_program_status;
    assign link_word_o = cur_ff.link;
    assign link_valid_o = cur_ff.link_vld;
    assign irq_allowed_o = cur_ff.irq_ok;
    assign mode_sel_o = cur_ff.current_program_status[MSEL_HI:MSEL_LO];
    assign mode_undef_o = cur_ff.mode_undef;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!arst_n_i);

    chk_decode_latency: assert property (instr_valid_i |-> ##2 dec_valid_o)
        else $error("decode result did not follow two cycles after intake");

    chk_first_reg: assert property (instr_valid_i && instr_i[0:3] == NIB_RS |->
        ##2 reg1_o == $past(instr_i[R1_HI:R1_LO], 2))
        else $error("first register field not carried to output");

    chk_shift_no_r3: assert property (instr_valid_i && instr_i[0:7] >= SHIFT_LO &&
        instr_i[0:7] <= SHIFT_HI |-> ##2 !reg3_valid_o && reg3_o == 4'h0)
        else $error("third register field used by a shift");

    chk_zero_base: assert property (instr_valid_i && instr_i[0:3] == NIB_RS &&
        instr_i[B1_HI:B1_LO] == 4'h0 |-> ##2 addr2_o == {12'h000, $past(instr_i[D1_HI:D1_LO], 2)})
        else $error("zero base field did not give base zero");

    chk_full_load: assert property (psw_load_i |=> psw_o == $past(psw_new_i))
        else $error("status word not replaced whole");

    chk_sys_mask_only: assert property (sys_mask_load_i && !psw_load_i && !prog_mask_load_i &&
        !exec_update_i |=> psw_o[SM_HI:SM_LO] == $past(sys_mask_i) && $stable(psw_o[MODE_HI:IA_LO]))
        else $error("system mask load touched other bits");

    chk_link_word: assert property (branch_link_i |=> link_valid_o &&
        link_word_o == $past(psw_o[LOW_HI:LOW_LO]))
        else $error("link word is not the low status half");

    chk_irq_gate: assert property (##1 irq_allowed_o ==
        ($past(irq_pending_i) & $past(psw_o[SM_HI:SM_LO])))
        else $error("interrupt level passed without its mask bit");

    chk_mode_undef: assert property (psw_load_i && psw_new_i[MSEL_HI:MSEL_LO] == MSEL_UNDEF_B |=>
        mode_undef_o && mode_sel_o == MSEL_UNDEF_B)
        else $error("undefined mode code not flagged");

endmodule : ifp_decode

// >>> rtl/ifp_len_decode.sv
`timescale 1ns/1ns
module ifp_len_decode
    import ifp_pkg::*;
(
    input wire logic [7:0] op_i,
    input wire logic [7:0] len_byte_i,
    output logic [7:0] len1_o,
    output logic [7:0] len2_o,
    output logic len2_vld_o,
    output logic secop_vld_o
);

    logic first_only;

    assign first_only = (op_i == OP_TRANSLATE) || (op_i == OP_TRANS_TEST) ||
                        (op_i == OP_EDIT) || (op_i == OP_EDIT_MARK);

    always_comb
    begin
        len1_o = 8'h00;
        len2_o = 8'h00;
        len2_vld_o = 1'b0;
        secop_vld_o = 1'b0;
        if (op_i == OP_EMUL_AID)
        begin
            secop_vld_o = 1'b1;
        end
        else if (op_i[7:4] == NIB_DEC)
        begin
            len1_o = {4'h0, len_byte_i[7:4]};
            len2_o = {4'h0, len_byte_i[3:0]};
            len2_vld_o = 1'b1;
        end
        else if (op_i[7:4] == NIB_LOG)
        begin
            len1_o = len_byte_i;
            len2_o = first_only ? 8'h00 : len_byte_i;
            len2_vld_o = !first_only;
        end
    end

endmodule : ifp_len_decode

// >>> rtl/ifp_pkg.sv
package ifp_pkg;

    localparam int INSTR_W = 48;
    localparam int ADDR_W = 24;
    localparam int PSW_W = 64;
    localparam int NMASK = 13;

    // Instruction fields, bit 0 is the most significant bit of the instruction.
    localparam int OP_HI = 0;
    localparam int OP_LO = 7;
    localparam int R1_HI = 8;
    localparam int R1_LO = 11;
    localparam int R3_HI = 12;
    localparam int R3_LO = 15;
    localparam int B1_HI = 16;
    localparam int B1_LO = 19;
    localparam int D1_HI = 20;
    localparam int D1_LO = 31;
    localparam int B2_HI = 32;
    localparam int B2_LO = 35;
    localparam int D2_HI = 36;
    localparam int D2_LO = 47;

    // Relocation offset inside the relocation word.
    localparam int RELOC_HI = 8;
    localparam int RELOC_LO = 19;

    // Status word layout, bit 0 is the most significant bit.
    localparam int SM_HI = 0;
    localparam int SM_LO = 12;
    localparam int MODE_HI = 13;
    localparam int MODE_LO = 19;
    localparam int MSEL_HI = 13;
    localparam int MSEL_LO = 15;
    localparam int KEY_HI = 20;
    localparam int KEY_LO = 23;
    localparam int MEXT_HI = 24;
    localparam int MEXT_LO = 31;
    localparam int ILC_HI = 32;
    localparam int ILC_LO = 33;
    localparam int CC_HI = 34;
    localparam int CC_LO = 35;
    localparam int PM_HI = 36;
    localparam int PM_LO = 41;
    localparam int IA_HI = 42;
    localparam int IA_LO = 63;
    localparam int LOW_HI = 32;
    localparam int LOW_LO = 63;
    localparam logic [PSW_W-1:0] PSW_RST = 64'h0000_0000_0000_0000;

    // Mode select codes.
    localparam logic [2:0] MSEL_NATIVE = 3'h0;
    localparam logic [2:0] MSEL_COMPAT = 3'h1;
    localparam logic [2:0] MSEL_SPCOMPAT = 3'h2;
    localparam logic [2:0] MSEL_UNDEF_A = 3'h3;
    localparam logic [2:0] MSEL_EMUL1 = 3'h4;
    localparam logic [2:0] MSEL_UNDEF_B = 3'h6;
    localparam logic [2:0] MSEL_UNDEF_C = 3'h7;

    // Op code classes.
    localparam logic [3:0] NIB_RS = 4'h8;
    localparam logic [1:0] TOP_SS = 2'h3;
    localparam logic [1:0] TOP_RSSI = 2'h2;
    localparam logic [3:0] NIB_DEC = 4'hF;
    localparam logic [3:0] NIB_LOG = 4'hD;
    localparam logic [7:0] SHIFT_LO = 8'h88;
    localparam logic [7:0] SHIFT_HI = 8'h8F;
    localparam logic [7:0] IO_LO = 8'h9C;
    localparam logic [7:0] IO_HI = 8'h9F;
    localparam logic [7:0] OP_MASK_TEST = 8'h91;
    localparam logic [7:0] OP_IMM_NONE = 8'h90;
    localparam logic [7:0] OP_EMUL_AID = 8'hD0;
    localparam logic [7:0] OP_TRANSLATE = 8'hDC;
    localparam logic [7:0] OP_TRANS_TEST = 8'hDD;
    localparam logic [7:0] OP_EDIT = 8'hDE;
    localparam logic [7:0] OP_EDIT_MARK = 8'hDF;

    typedef enum logic [1:0] {FMT_NONE, FMT_RS, FMT_SI, FMT_SS} ifp_fmt_t;
    typedef enum logic [1:0] {IMM_IGNORED, IMM_OPERAND, IMM_MASK, IMM_SECOP} ifp_imm_use_t;

endpackage : ifp_pkg

// >>> sim/ifp_fetch_model.sv
`timescale 1ns/1ns
// Register file and relocation word as the datapath presents them; reads are combinational.
module ifp_fetch_model
    import ifp_pkg::*;
#(
    parameter logic [31:0] RELOC_WORD = 32'h12AB_C345
)
(
    input wire logic [3:0] gpr_addr_a_i,
    input wire logic [3:0] gpr_addr_b_i,
    output logic [31:0] gpr_data_a_o,
    output logic [31:0] gpr_data_b_o,
    output logic [0:31] reloc_word_o
);
    // Every register repeats its own number, so a wrong selection shows as a wrong address.
    // Register zero holds a non-zero value on purpose, and the top byte catches an uncut base.
    assign gpr_data_a_o = {8'h5A, 4'h7, {5{gpr_addr_a_i}}};
    assign gpr_data_b_o = {8'h5A, 4'h7, {5{gpr_addr_b_i}}};
    assign reloc_word_o = RELOC_WORD;
endmodule : ifp_fetch_model

// >>> sim/tb_top.sv
`timescale 1ns/1ns
module tb_top;
    import ifp_pkg::*;
    logic clock_i = 1'b0;
    logic arst_n_i, instr_valid_i, reloc_req_i, psw_load_i, sys_mask_load_i, prog_mask_load_i;
    logic exec_update_i, branch_link_i, dec_valid_o, reg3_valid_o, shift_o, io_o, len2_valid_o;
    logic secop_valid_o, link_valid_o, mode_undef_o;
    logic [0:INSTR_W-1] instr_i;
    logic [31:0] gpr_data_a_i, gpr_data_b_i, link_word_o;
    logic [0:31] reloc_word_i;
    logic [0:PSW_W-1] psw_new_i, psw_o;
    logic [0:NMASK-1] sys_mask_i, irq_pending_i, irq_allowed_o;
    logic [5:0] prog_mask_i, shift_count_o;
    logic [1:0] ilc_i, cc_i, fmt_o, imm_use_o;
    logic [21:0] next_ia_i;
    logic [3:0] gpr_addr_a_o, gpr_addr_b_o, reg1_o, reg3_o, io_chan_o;
    logic [7:0] opcode_o, imm_byte_o, io_dev_o, len1_o, len2_o;
    logic [ADDR_W-1:0] addr1_o, addr2_o;
    logic [2:0] mode_sel_o;
    int mismatches = 0;
    int total_checks = 0;

    always #50 clock_i = ~clock_i;

    ifp_fetch_model u_far (.gpr_addr_a_i(gpr_addr_a_o), .gpr_addr_b_i(gpr_addr_b_o),
        .gpr_data_a_o(gpr_data_a_i), .gpr_data_b_o(gpr_data_b_i), .reloc_word_o(reloc_word_i));

    ifp_decode dut (.clock_i(clock_i), .arst_n_i(arst_n_i), .instr_valid_i(instr_valid_i), .instr_i(instr_i),
        .gpr_data_a_i(gpr_data_a_i), .gpr_data_b_i(gpr_data_b_i), .reloc_word_i(reloc_word_i),
        .reloc_req_i(reloc_req_i), .psw_load_i(psw_load_i), .psw_new_i(psw_new_i),
        .sys_mask_load_i(sys_mask_load_i), .sys_mask_i(sys_mask_i), .prog_mask_load_i(prog_mask_load_i),
        .prog_mask_i(prog_mask_i), .exec_update_i(exec_update_i), .ilc_i(ilc_i), .cc_i(cc_i),
        .next_ia_i(next_ia_i), .branch_link_i(branch_link_i), .irq_pending_i(irq_pending_i),
        .gpr_addr_a_o(gpr_addr_a_o), .gpr_addr_b_o(gpr_addr_b_o), .dec_valid_o(dec_valid_o), .fmt_o(fmt_o),
        .opcode_o(opcode_o), .reg1_o(reg1_o), .reg3_o(reg3_o), .reg3_valid_o(reg3_valid_o),
        .imm_byte_o(imm_byte_o), .imm_use_o(imm_use_o), .addr1_o(addr1_o), .addr2_o(addr2_o),
        .shift_o(shift_o), .shift_count_o(shift_count_o), .io_o(io_o), .io_chan_o(io_chan_o),
        .io_dev_o(io_dev_o), .len1_o(len1_o), .len2_o(len2_o), .len2_valid_o(len2_valid_o),
        .secop_valid_o(secop_valid_o), .psw_o(psw_o), .link_word_o(link_word_o), .link_valid_o(link_valid_o),
        .irq_allowed_o(irq_allowed_o), .mode_sel_o(mode_sel_o), .mode_undef_o(mode_undef_o));

    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
        total_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    function automatic logic [23:0] base_of(input logic [3:0] b);
        base_of = (b == 4'h0) ? 24'h000000 : {4'h7, {5{b}}};
    endfunction : base_of

    // One instruction in; the decode pulse is looked at in the cycle where it stands.
    task automatic decode(input logic [0:47] ins, input logic req);
        @(negedge clock_i);
        instr_i = ins;
        instr_valid_i = 1'b1;
        reloc_req_i = req;
        @(negedge clock_i);
        instr_valid_i = 1'b0;
        @(negedge clock_i);
        chk(dec_valid_o, 1'b1, "decode pulse");
        chk(opcode_o, ins[0:7], "op code");
    endtask : decode

    task automatic psw_step(input logic [4:0] en);
        @(negedge clock_i);
        {psw_load_i, sys_mask_load_i, prog_mask_load_i, exec_update_i, branch_link_i} = en;
        @(negedge clock_i);
        {psw_load_i, sys_mask_load_i, prog_mask_load_i, exec_update_i, branch_link_i} = 5'h00;
    endtask : psw_step

    task automatic test_rs();
        logic [3:0] b;
        for (int i = 0; i < 2; i++)
        begin
            b = (i == 0) ? 4'h2 : 4'h0;
            decode({8'h86, 4'h3, 4'h5, b, 12'h7F0, 16'h0000}, 1'b1);
            chk({fmt_o, reg1_o, reg3_valid_o, reg3_o}, {FMT_RS, 4'h3, 1'b1, 4'h5}, "rs fields");
            chk(addr2_o, 24'h0007F0 + base_of(b), "rs address");
            chk({shift_o, addr1_o}, 25'h0, "rs without shift or offset");
        end
        decode({8'h8A, 4'h3, 4'h7, 4'h4, 12'h003, 16'h0000}, 1'b0);
        chk({shift_o, reg3_valid_o}, 2'b10, "shift ignores third reg");
        chk(shift_count_o, 6'(24'h000003 + base_of(4'h4)), "shift count");
        $display("test_rs finished");
    endtask : test_rs

    task automatic test_si();
        logic [7:0] ops [4] = '{8'h92, 8'h91, 8'h9C, 8'h90};
        logic [1:0] uses [4] = '{IMM_OPERAND, IMM_MASK, IMM_SECOP, IMM_IGNORED};
        for (int i = 0; i < 4; i++)
        begin
            decode({ops[i], 8'hC3, 4'h1, 12'hA5F, 16'h0000}, i[0]);
            chk(imm_use_o, uses[i], "immediate use");
            chk({fmt_o, imm_byte_o, io_o}, {FMT_SI, 8'hC3, i == 2}, "si fields");
            if (i != 2)
                chk(addr1_o, 24'h000A5F + base_of(4'h1) + (i[0] ? 24'h000ABC : 24'h0), "si address");
            if (i == 2)
                chk({io_chan_o, io_dev_o}, 12'hA5F, "channel and device");
        end
        $display("test_si finished");
    endtask : test_si

    task automatic test_ss();
        logic [7:0] ops [4] = '{8'hF2, 8'hD2, 8'hDC, 8'hD0};
        for (int i = 0; i < 4; i++)
        begin
            decode({ops[i], 8'h4B, 4'h6, 12'h123, 4'(i), 12'hFFF}, 1'b1);
            chk({fmt_o, secop_valid_o}, {FMT_SS, i == 3}, "ss format");
            if (i < 3)
            begin
                chk(addr1_o, 24'h000123 + base_of(4'h6) + 24'h000ABC, "ss first address");
                chk(addr2_o, 24'h000FFF + base_of(4'(i)), "ss second address");
                chk(len2_valid_o, i < 2, "second length valid");
            end
            if (i == 0)
                chk({len1_o, len2_o}, 16'h040B, "decimal lengths");
            if (i == 1)
                chk({len1_o, len2_o}, 16'h4B4B, "logical length");
            if (i == 2)
                chk(len1_o, 8'h4B, "translate length");
        end
        $display("test_ss finished");
    endtask : test_ss

    task automatic test_psw();
        // Only the defined mode codes are loaded; the others leave the machine indeterminate.
        logic [2:0] codes [4] = '{3'h0, 3'h1, 3'h2, 3'h4};
        logic [0:63] exp;
        chk(psw_o, 64'h0, "status after reset");
        chk(mode_sel_o, MSEL_NATIVE, "native mode after reset");
        for (int i = 0; i < 4; i++)
        begin
            exp = {13'h1A5A, codes[i], 4'h9, 4'h3, 8'hC6, 2'h1, 2'h2, 6'h2D, 22'h2ABCDE};
            psw_new_i = exp;
            psw_step(5'b10000);
            chk(psw_o, exp, "status load");
            chk({mode_sel_o, mode_undef_o}, {codes[i], 1'b0}, "mode code");
        end
        {sys_mask_i, prog_mask_i, ilc_i, cc_i, next_ia_i} = {13'h0F0F, 6'h15, 2'h3, 2'h0, 22'h012345};
        irq_pending_i = 13'h1C71;
        exp[SM_HI:SM_LO] = 13'h0F0F;
        exp[PM_HI:PM_LO] = 6'h15;
        exp[ILC_HI:IA_LO] = {2'h3, 2'h0, 6'h15, 22'h012345};
        psw_step(5'b01110);
        chk(psw_o, exp, "partial updates");
        chk(psw_o[LOW_HI:LOW_LO], exp[LOW_HI:LOW_LO], "running fields");
        chk(irq_allowed_o, 13'h1850, "old mask gates");
        @(negedge clock_i);
        chk(irq_allowed_o, 13'h0C01, "new mask gates");
        psw_step(5'b00001);
        chk({link_valid_o, link_word_o}, {1'b1, exp[LOW_HI:LOW_LO]}, "link word");
        sys_mask_i = 13'h0AAA;
        exp[SM_HI:SM_LO] = 13'h0AAA;
        psw_step(5'b01000);
        chk(psw_o, exp, "system mask alone");
        exp[SM_HI:MSEL_LO] = {13'h0123, 3'h1};
        psw_new_i = exp;
        sys_mask_i = 13'h1FFF;
        psw_step(5'b11110);
        chk(psw_o, exp, "whole load wins");
        chk(link_valid_o, 1'b0, "link pulse ended");
        chk(mode_sel_o, 3'h1, "mode field place");
        $display("test_psw finished");
    endtask : test_psw

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : report_and_stop

    initial
    begin
        arst_n_i = 1'b0;
        {instr_valid_i, reloc_req_i, psw_load_i, sys_mask_load_i, prog_mask_load_i} = 5'h00;
        {exec_update_i, branch_link_i, instr_i, psw_new_i} = 114'h0;
        {sys_mask_i, irq_pending_i, prog_mask_i, ilc_i, cc_i, next_ia_i} = 58'h0;
        repeat (3) @(negedge clock_i);
        arst_n_i = 1'b1;
        test_psw();
        test_rs();
        test_si();
        test_ss();
        report_and_stop();
    end

    // The tests need well under a thousand cycles; this span leaves a wide margin.
    initial
    begin
        #200000;
        mismatches++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        report_and_stop();
    end
endmodule : tb_top
